// ### rtl/clock_power_regs.vh
/*
  Constants for the power management clock control block: register offsets,
  bit positions, reset value and timing counts.
  Assumes inclusion by its bare name from a file under rtl/.
*/
`ifndef CLOCK_POWER_REGS_VH
`define CLOCK_POWER_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SYS_CLK_CTRL_ADDR    8'h0E
`define SYS_CLK_CTRL_RESET   8'h01
`define CD_LSB               0
`define CD_MSB               1
`define LOW_POWER_DIVIDE_ENABLE_BIT             2
`define SWB_BIT              3
`define STOP_BIT             4
`define STATUS_ADDR          8'h0F

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RC_WAKE_CYCLES       4
`define HF_WARMUP_CYCLES     4096
`define DIV256_COUNT         256

`endif

// ### rtl/power_management_clock_control.v
/*
  Power management clock control: system clock divide (1/2/4/8),
  divide-by-256 low-power mode, automatic switchback, and stop mode
  with wake-up and clock source restore sequencing.
  Assumes all inputs synchronous to clk; the divided system clock is
  delivered as a one-cycle enable pulse (sys_clk_en). RC and high
  frequency oscillator cycles arrive as one-cycle tick inputs.
*/
`timescale 1ns/1ps
`include "clock_power_regs.vh"
`default_nettype none

// What this block does
// RL1: With low-power off, divide field selects divide by 1, 2, 4 or 8.
// RL2: Low-power enable with divide field 00 divides the source by 256.
// RL3: Core and peripherals use divided clock; watchdog keeps undivided RC clock.
// RL4: Software clears the divide field before setting low-power enable.
// RL5: Leaving divide-by-256 reverts to the divide field rate.
// RL6: With auto return on in divide-by-256 mode, any switchback source clears low-power enable.
// RL7: Enabled port interrupt or serial receive falling edge are switchback sources.
// RL8: Serial buffer write with transmit enabled is a switchback source.
// RL9: SPI master buffer write or slave select in slave mode cause switchback.
// RL10: CAN receive activity or debug mode entry cause switchback.
// RL11: Writes setting low-power enable ignored while auto return on and source active.
// RL12: Setting the stop bit halts all clocks including watchdog and RC.
// RL13: Stop leaves the clock control settings unchanged.
// RL14: Stop exits on reset, port or CAN interrupt, brownout interrupt or reset.
// RL15: Reset-caused stop exit performs a full reset sequence.
// RL16: Interrupt-caused stop exit resumes then vectors to the interrupt routine.
// RL17: RC source selected: interrupt wake restarts on RC after four RC cycles; reset wake restarts at once.
// RL18: HF selected: interrupt wake restarts on RC, switches to HF after 4096 HF cycles; reset wake uses HF at once.
// RL19: Hardware clears the stop bit when stop mode is exited.
module power_management_clock_control
(
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr_en,
  input  wire        rd_en,
  output reg  [7:0]  rdata,
  input  wire        ext_int_event,
  input  wire        ext_int_enable,
  input  wire        serial_rx_in,
  input  wire [1:0]  serial_mode,
  input  wire        serial_rx_enable,
  input  wire        serial_data_buffer_wr,
  input  wire        serial_tx_enable,
  input  wire        spi_data_buffer_wr,
  input  wire        spi_master_select,
  input  wire        spi_tx_enable,
  input  wire        spi_slave_select_n,
  input  wire        can_receive_input,
  input  wire        can_int_enable,
  input  wire        debug_entry,
  input  wire        brownout_int,
  input  wire        brownout_int_enable,
  input  wire        ext_reset_in,
  input  wire        por_brownout_reset,
  input  wire        brownout_reset_enable,
  input  wire        external_source_select,
  input  wire        rc_tick,
  input  wire        hf_tick,
  output reg         sys_clk_en,
  output reg         rc_osc_run,
  output reg         watchdog_clk_en,
  output reg         use_hf_source,
  output reg         stop_active,
  output reg         wake_reset_req,
  output reg         wake_int_vector
);

  // ----------------------------------------------------------------
  // Constants cut to the widths they load
  // ----------------------------------------------------------------
  localparam [7:0]   CTRL_RESET    = `SYS_CLK_CTRL_RESET;
  localparam integer DIV256_LAST_I = `DIV256_COUNT - 1;
  localparam [7:0]   DIV256_LAST   = DIV256_LAST_I[7:0];

  // ----------------------------------------------------------------
  // Control register and switchback sources
  // ----------------------------------------------------------------
  reg  [1:0]  clock_divide_select_reg;
  reg         low_power_divide_enable_reg;
  reg         auto_return_enable_reg;
  reg         stop_reg;
  reg         rx_prev_reg;
  reg         can_prev_reg;
  reg         ss_prev_n_reg;
  wire        rx_fall;
  wire        can_edge;
  wire        ss_assert;
  wire        switchback_src;
  wire        divide_256_mode;
  wire        wr_ctrl;
  wire        low_power_divide_enable_wr_ok;
  wire        wake_rst_src;
  wire        wake_int_src;

  assign rx_fall   = rx_prev_reg & ~serial_rx_in;
  assign can_edge  = can_prev_reg ^ can_receive_input;
  assign ss_assert = ss_prev_n_reg & ~spi_slave_select_n & ~spi_master_select;

  assign switchback_src =
      (ext_int_event & ext_int_enable)                                 // see RL7
    | (rx_fall & serial_rx_enable & (serial_mode != 2'h0))             // see RL7
    | (serial_data_buffer_wr & serial_tx_enable)                       // see RL8
    | (spi_data_buffer_wr & spi_master_select & spi_tx_enable)         // see RL9
    | ss_assert                                                        // see RL9
    | (can_edge & can_int_enable)                                      // see RL10
    | debug_entry;                                                     // see RL10

  assign divide_256_mode = low_power_divide_enable_reg &
                           (clock_divide_select_reg == 2'h0);          // see RL2
  assign wr_ctrl    = wr_en & (addr == `SYS_CLK_CTRL_ADDR);
  // Set blocked during source activity so service is not slowed
  assign low_power_divide_enable_wr_ok = ~(auto_return_enable_reg & switchback_src);     // see RL11

  assign wake_rst_src = ext_reset_in |
                        (por_brownout_reset & brownout_reset_enable); // see RL14
  // Brownout interrupt resumes like a port interrupt
  assign wake_int_src = (ext_int_event & ext_int_enable) |
                        (can_edge & can_int_enable) |
                        (brownout_int & brownout_int_enable);         // see RL14

  // ----------------------------------------------------------------
  // Activity edge detectors
  // ----------------------------------------------------------------
  // Idle levels loaded in reset so no false edge follows it
  always @(posedge clk)
  begin
    if (rst)
    begin
      rx_prev_reg   <= 1'b1;
      can_prev_reg  <= 1'b1;
      ss_prev_n_reg <= 1'b1;
    end
    else
    begin
      rx_prev_reg   <= serial_rx_in;
      can_prev_reg  <= can_receive_input;
      ss_prev_n_reg <= spi_slave_select_n;
    end
  end

  // ----------------------------------------------------------------
  // Stop / wake state machine
  // ----------------------------------------------------------------
  localparam [1:0] ST_RUN     = 2'h0;
  localparam [1:0] ST_STOP    = 2'h1;
  localparam [1:0] ST_RC_WAIT = 2'h2;
  localparam [1:0] ST_HF_WARM = 2'h3;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [2:0]  rc_cnt_reg;
  reg  [12:0] hf_cnt_reg;
  reg         hf_pending_reg;
  wire        running;

  // HF warmup still executes code, on the RC clock
  assign running = (state_reg == ST_RUN) | (state_reg == ST_HF_WARM);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (stop_reg)
          state_next = ST_STOP;                                         // see RL12
      // Reset-type wakes are taken in the clocked process
      ST_STOP:
        if (wake_int_src)
          state_next = ST_RC_WAIT;
      ST_RC_WAIT:
        if (rc_tick && rc_cnt_reg == (`RC_WAKE_CYCLES - 1))
          state_next = hf_pending_reg ? ST_HF_WARM : ST_RUN;           // see RL17
      ST_HF_WARM:
        if (stop_reg)
          state_next = ST_STOP;
        else if (hf_tick && hf_cnt_reg == (`HF_WARMUP_CYCLES - 1))
          state_next = ST_RUN;                                          // see RL18
      default:
        state_next = ST_RUN;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      state_reg      <= ST_RUN;
      rc_cnt_reg     <= 3'h0;
      hf_cnt_reg     <= 13'h0000;
      hf_pending_reg <= 1'b0;
    end
    else if (wake_rst_src)
    begin
      // Reset-caused wake restarts the whole sequence, see RL15
      state_reg      <= ST_RUN;
      rc_cnt_reg     <= 3'h0;
      hf_cnt_reg     <= 13'h0000;
      hf_pending_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_STOP)
      begin
        rc_cnt_reg     <= 3'h0;
        hf_cnt_reg     <= 13'h0000;
        hf_pending_reg <= external_source_select;
      end
      else if (state_reg == ST_RC_WAIT && rc_tick)
        rc_cnt_reg <= rc_cnt_reg + 3'h1;
      else if (state_reg == ST_HF_WARM && hf_tick)
        hf_cnt_reg <= hf_cnt_reg + 13'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Control register writes and hardware updates
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rst | wake_rst_src)
    begin
      clock_divide_select_reg     <= CTRL_RESET[`CD_MSB:`CD_LSB];
      low_power_divide_enable_reg <= 1'b0;
      auto_return_enable_reg      <= 1'b0;
      stop_reg                    <= 1'b0;
    end
    else
    begin
      // Stop never touches divide settings, see RL13
      if (wr_ctrl && running)
      begin
        clock_divide_select_reg <= wdata[`CD_MSB:`CD_LSB];
        auto_return_enable_reg  <= wdata[`SWB_BIT];
        stop_reg                <= wdata[`STOP_BIT];
        if (!wdata[`LOW_POWER_DIVIDE_ENABLE_BIT] || low_power_divide_enable_wr_ok)
          low_power_divide_enable_reg <= wdata[`LOW_POWER_DIVIDE_ENABLE_BIT];             // see RL11
      end
      // Hardware clear wins over a same-cycle software set
      if (auto_return_enable_reg && divide_256_mode && switchback_src)
        low_power_divide_enable_reg <= 1'b0;                           // see RL6
      if (state_reg == ST_STOP && wake_int_src)
        stop_reg <= 1'b0;                                              // see RL19
    end
  end

  // ----------------------------------------------------------------
  // System clock divider
  // ----------------------------------------------------------------
  reg  [7:0]  div_cnt_reg;
  reg  [7:0]  div_last;
  wire        halt_next;

  // Drop the enable on the edge that enters stop, not one later
  assign halt_next = (state_next == ST_STOP);

  always @*
  begin
    if (divide_256_mode)
      div_last = DIV256_LAST;                                           // see RL2
    else
      case (clock_divide_select_reg)                                   // see RL1
        2'h0:    div_last = 8'h00;
        2'h1:    div_last = 8'h01;
        2'h2:    div_last = 8'h03;
        2'h3:    div_last = 8'h07;
        default: div_last = 8'h00;
      endcase
  end

  // A count at or past the new limit fires at once, so revert takes effect at once
  always @(posedge clk)
  begin
    if (rst | ~running | halt_next)
    begin
      div_cnt_reg <= 8'h00;
      sys_clk_en  <= 1'b0;                                             // see RL12
    end
    else if (div_cnt_reg >= div_last)
    begin
      div_cnt_reg <= 8'h00;
      sys_clk_en  <= 1'b1;                                             // see RL3 RL5
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      sys_clk_en  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and register read
  // ----------------------------------------------------------------
  reg  [7:0]  rdata_next;
  wire        hf_select_next;

  // HF whenever run state is next; only interrupt wakes run on RC and warm up first
  assign hf_select_next = external_source_select & (state_next == ST_RUN);

  // Read data stand only in the slot after the strobe
  always @*
  begin
    rdata_next = 8'h00;
    if (rd_en && addr == `SYS_CLK_CTRL_ADDR)
      rdata_next = {3'h0, stop_reg, auto_return_enable_reg,
                    low_power_divide_enable_reg, clock_divide_select_reg};
    else if (rd_en && addr == `STATUS_ADDR)
      rdata_next = {4'h0, switchback_src, divide_256_mode, state_reg};
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      rdata           <= 8'h00;
      rc_osc_run      <= 1'b1;
      watchdog_clk_en <= 1'b1;
      use_hf_source   <= 1'b0;
      stop_active     <= 1'b0;
      wake_reset_req  <= 1'b0;
      wake_int_vector <= 1'b0;
    end
    else
    begin
      rc_osc_run      <= (state_next != ST_STOP);                      // see RL12
      watchdog_clk_en <= (state_next != ST_STOP);                      // see RL3
      use_hf_source   <= hf_select_next;                               // see RL18
      stop_active     <= (state_next == ST_STOP);
      wake_reset_req  <= wake_rst_src & (state_reg == ST_STOP);        // see RL15
      wake_int_vector <= (state_reg == ST_RC_WAIT) &&
                         (state_next != ST_RC_WAIT);                   // see RL16
      rdata           <= rdata_next;
    end
  end

endmodule

`default_nettype wire

// ### tb/osc_consumer_model.sv
/*
  Oscillator ticks and divided clock consumer beside the clock control.
  Assumes one bench clock; RC_DIV sets how slowly the RC side ticks.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_consumer_model
#(
  parameter int RC_DIV = 3
)
(
  input  wire logic clk,
  input  wire logic rc_run,
  input  wire logic sys_clk_en,
  output var  logic rc_tick,
  output var  logic hf_tick,
  output var  int   n_edges
);
  int div = 0;
  int n_count = 0;
  assign n_edges = n_count;
  // Oscillators halted in stop give no ticks at all
  always @(posedge clk)
  begin
    div <= rc_run ? (div + 1) % RC_DIV : 0;
    rc_tick <= rc_run && div == RC_DIV - 1;
    hf_tick <= rc_run;
    if (sys_clk_en)
      n_count <= n_count + 1;
  end
endmodule
`default_nettype wire

// ### tb/pmcc_checker.sv
/*
  Port assertions for the clock control block.
  Assumes binding to its top module, one clock, reset synchronous high.
*/
`timescale 1ns/1ps
`default_nettype none
module pmcc_checker
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rdata,
  input wire logic       ext_reset_in,
  input wire logic       external_source_select,
  input wire logic       sys_clk_en,
  input wire logic       rc_osc_run,
  input wire logic       watchdog_clk_en,
  input wire logic       use_hf_source,
  input wire logic       stop_active,
  input wire logic       wake_reset_req,
  input wire logic       wake_int_vector
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_STOP_HALT: assert property (stop_active |-> !rc_osc_run && !watchdog_clk_en
    && !sys_clk_en) else $error("clock runs in stop");
  AST_RUN_OSC: assert property (!stop_active |-> rc_osc_run && watchdog_clk_en)
    else $error("rc clock off outside stop");
  AST_STOP_ENTRY: assert property (wr_en && addr == 8'h0E && wdata[4] && !stop_active
    |-> ##[2:3] stop_active) else $error("stop not entered");
  AST_RESET_WAKE: assert property (stop_active && ext_reset_in
    |-> ##[1:3] wake_reset_req) else $error("no reset on wake");
  AST_VEC_PULSE: assert property (wake_int_vector |=> !wake_int_vector)
    else $error("vector pulse too long");
  AST_HF_ROSE: assert property ($rose(use_hf_source) |-> external_source_select)
    else $error("hf used while not selected");
  AST_RD_IDLE: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  AST_RST_VAL: assert property (disable iff (1'b0) rst |=> rc_osc_run && !stop_active
    && !sys_clk_en) else $error("bad reset outputs");
endmodule
bind power_management_clock_control pmcc_checker i_chk (.clk, .rst, .addr, .wdata, .wr_en,
  .rd_en, .rdata, .ext_reset_in, .external_source_select, .sys_clk_en, .rc_osc_run,
  .watchdog_clk_en, .use_hf_source, .stop_active, .wake_reset_req, .wake_int_vector);
`default_nettype wire

// ### tb/power_management_clock_control_test.sv
/*
  Self-checking bench for the clock control block.
  Assumes the oscillator model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module power_management_clock_control_test;
  logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, en = 1, ext_int_event = 0, serial_rx_in = 1;
  logic tx_wr = 0, spi_wr = 0, spi_master_select = 1, ss_n = 1, can_rx = 1, debug_entry = 0;
  logic brownout_int = 0, ext_reset_in = 0, por_rst = 0, external_source_select = 0;
  logic [1:0] serial_mode = 2'h1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic sys_clk_en, rc_osc_run, use_hf_source, stop_active, wake_reset_req, wake_int_vector;
  logic rc_tick, hf_tick, wdog;
  int seed = 32'hAB80, n_mismatch = 0, n_tests = 0, n_edges, ctl, i, k;
  int srcs[$] = '{0, 1, 2, 3, 4, 5, 6};
  int wakes[$] = '{0, 5, 7, 8, 9};
  always #4 clk = ~clk;
  power_management_clock_control i_dut (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .ext_int_event, .ext_int_enable(en), .serial_rx_in, .serial_mode, .serial_rx_enable(en),
    .serial_data_buffer_wr(tx_wr), .serial_tx_enable(en), .spi_data_buffer_wr(spi_wr),
    .spi_master_select, .spi_tx_enable(en), .spi_slave_select_n(ss_n),
    .can_receive_input(can_rx), .can_int_enable(en), .debug_entry, .brownout_int,
    .brownout_int_enable(en), .ext_reset_in, .por_brownout_reset(por_rst),
    .brownout_reset_enable(en), .external_source_select, .rc_tick, .hf_tick, .sys_clk_en,
    .rc_osc_run, .watchdog_clk_en(wdog), .use_hf_source, .stop_active, .wake_reset_req,
    .wake_int_vector);
  osc_consumer_model i_osc (.clk, .rc_run(rc_osc_run), .sys_clk_en, .rc_tick, .hf_tick,
    .n_edges);
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  // Settle first so a rate change never straddles the window
  task cnt(input int n, input int e);
    int c0;
    repeat (16) @(posedge clk);
    #1 c0 = n_edges;
    repeat (n) @(posedge clk);
    #1 chk("pulses", 16'(n_edges - c0), 16'(e));
  endtask
  task pulse(input int s);
    @(posedge clk);
    serial_mode <= 2'(1 + {$random(seed)} % 3);
    spi_master_select <= s != 4;
    case (s)
      0: ext_int_event <= 1'b1;
      1: serial_rx_in <= 1'b0;
      2: tx_wr <= 1'b1;
      3: spi_wr <= 1'b1;
      4: ss_n <= 1'b0;
      5: can_rx <= ~can_rx;
      6: debug_entry <= 1'b1;
      7: brownout_int <= 1'b1;
      8: ext_reset_in <= 1'b1;
      default: por_rst <= 1'b1;
    endcase
    @(posedge clk);
    {ext_int_event, tx_wr, spi_wr, debug_entry, brownout_int, ext_reset_in, por_rst} <= 7'h00;
    {serial_rx_in, ss_n} <= 2'h3;
  endtask
  task wt(input int s);
    for (i = 0; i < 6000; i++)
    begin
      #1;
      if (s == 0 && wake_int_vector === 1'b1 || s == 1 && wake_reset_req === 1'b1
          || s == 2 && use_hf_source === 1'b1)
        return;
      @(posedge clk);
    end
    chk("wait", 16'h0000, 16'h0001);
    end_of_test;
  endtask
  task stopw(input int s);
    int cd;
    cd = {$random(seed)} % 4;
    repeat (32) @(posedge clk);
    wr(8'h0E, 8'(8'h10 | cd));
    repeat (3) @(posedge clk);
    #1 chk("stop", {stop_active, rc_osc_run, wdog}, 16'h0004);
    rd(8'h0F, 8'h01);
    pulse(s);
    wt(s > 7);
    chk("hf", use_hf_source, 16'h0000);
    ctl = s > 7 ? 1 : cd;
    rd(8'h0E, 8'(ctl));
    if (s < 8)
      cnt(64, 64 >> cd);
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(8'h0E, 8'h01);
    rd(8'h20, 8'h00);
    wr(8'h20, 8'hFF);
    rd(8'h0E, 8'h01);
    for (k = 0; k < 4; k++)
    begin
      wr(8'h0E, 8'(k));
      cnt(64, 64 >> k);
    end
    wr(8'h0E, 8'h00);
    wr(8'h0E, 8'h04);
    rd(8'h0F, 8'h04);
    cnt(512, 2);
    wr(8'h0E, 8'h00);
    cnt(64, 64);
    $display("divide done");
    foreach (srcs[j])
    begin
      wr(8'h0E, 8'h00);
      wr(8'h0E, 8'h0C);
      pulse(srcs[j]);
      rd(8'h0E, 8'h08);
      cnt(64, 64);
    end
    @(posedge clk);
    en <= 1'b0;
    wr(8'h0E, 8'h0C);
    foreach (wakes[j])
      pulse(wakes[j] % 4);
    rd(8'h0E, 8'h0C);
    @(posedge clk);
    en <= 1'b1;
    wr(8'h0E, 8'h08);
    @(posedge clk);
    addr <= 8'h0E;
    wdata <= 8'h0C;
    wr_en <= 1'b1;
    ext_int_event <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    ext_int_event <= 1'b0;
    rd(8'h0E, 8'h08);
    $display("switchback done");
    @(posedge clk);
    external_source_select <= 1'b1;
    stopw(0);
    wt(2);
    @(posedge clk);
    external_source_select <= 1'b0;
    foreach (wakes[j])
      stopw(wakes[j]);
    $display("stop done");
    end_of_test;
  end
endmodule
`default_nettype wire
